// ### design/csd_console.sv
/*
  console front end: scan counter, serial fetch of the data leg,
  display buffer, key latches and a wishbone register port.
  assumes a synchronous active-high reset, inputs synchronous to core_clk
  and a classic wishbone master that holds each request until ack.
*/
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps

module csd_console #(
  parameter int unsigned PUP_HOLD = csd_pkg::PUP_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // processor side
  input wire logic [15:0] data_leg,
  input wire logic power_good_n,
  input wire logic panel_lock,
  input wire logic [5:0] key_active,
  output logic [3:0] scan_select,
  output logic [15:0] lamps,
  output logic [5:0] keys_latched_n,
  output logic stop_request_latched_n,
  output logic set_address_latched_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  initial
  begin
    if (PUP_HOLD < 1 || PUP_HOLD >= (1 << 21))
      $error("csd_console: PUP_HOLD out of range");
  end

  csd_scan_if scan ();

  logic [20:0] hold_cnt;
  logic pup;
  logic drive;
  logic [7:0] step_div;
  logic [7:0] div;
  logic step_tick;
  logic mid_tick;
  logic [7:0] count;
  logic [7:0] next_count;
  logic shift_en;
  logic [5:0] key_q;
  csd_pkg::csd_bus_e bus_state;
  csd_pkg::csd_bus_e next_bus_state;
  logic bus_req;
  logic [4:0] fill_cnt;
  logic [4:0] sweep_shifts;
  logic sweep_clean;

  // power-up: held low for the restore period after reset and after each
  // return of the processor's power signal; low again once that signal falls
  always_ff @(posedge core_clk)
  begin
    if (rst)
      hold_cnt <= '0;
    else if (!power_good_n)
      hold_cnt <= '0;
    else if (hold_cnt != 21'(PUP_HOLD))
      hold_cnt <= hold_cnt + 21'h000001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pup <= 1'b0;
    else
      pup <= power_good_n && (hold_cnt == 21'(PUP_HOLD));
  end

  // common key drive; low drive with lockout off lets keys act
  always_ff @(posedge core_clk)
  begin
    if (rst)
      drive <= 1'b0;
    else
      drive <= pup & panel_lock;
  end

  // step divider: an enable from the core clock, not an oscillator
  assign step_tick = pup && (div == step_div - 8'h01);
  assign mid_tick = pup && (div == {1'b0, step_div[7:1]});

  always_ff @(posedge core_clk)
  begin
    if (rst)
      div <= '0;
    else if (!pup)
      div <= '0; // inhibited while power-up low
    else if (div == step_div - 8'h01)
      div <= '0;
    else
      div <= div + 8'h01;
  end

  // scan counter, steps only while power-up is high, wraps from 255 to 0
  assign next_count = count + 8'h01;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      count <= '0;
    else if (step_tick)
      count <= next_count; // advances at the step edge
  end

  // scan mode only while the upper nibble is zero
  assign shift_en = (count[7:4] == 4'h0);

  // inverse select makes state 0 fetch bit 15
  always_ff @(posedge core_clk)
  begin
    if (rst)
      scan_select <= 4'hf;
    else
      scan_select <= ~count[3:0];
  end

  // fetch at mid step so the selected bit has settled
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      scan.shift_pulse <= 1'b0;
      scan.serial_bit <= 1'b0;
    end
    else
    begin
      scan.shift_pulse <= mid_tick && shift_en;
      scan.serial_bit <= data_leg[scan_select];
    end
  end

  csd_display_buf #(
    .SECTIONS(4)
  ) u_buf (
    .core_clk(core_clk),
    .scan(scan.buffer)
  );

  // lamp lit for a stored one; buffer bits pass straight to lamps
  assign lamps = scan.lamps;

  // six key latches; stop key polarity is set by its wiring
  csd_key_latch #(
    .NKEYS(csd_pkg::NKEYS)
  ) u_keys (
    .core_clk(core_clk),
    .rst(rst),
    .key_active(key_active),
    .drive(drive),
    .latched_n(key_q)
  );

  // stop latch halts only when low; forced high under lockout while power-up is high
  assign keys_latched_n = key_q;
  assign stop_request_latched_n = key_q[csd_pkg::KEY_STOP];
  assign set_address_latched_n = key_q[csd_pkg::KEY_SET_ADDR];

  // wishbone: ack one cycle after the strobe, dropped the cycle after
  assign bus_req = wb_cyc_i && wb_stb_i;

  always_comb
  begin
    case (bus_state)
      csd_pkg::CSD_BUS_IDLE:
        next_bus_state = bus_req ? csd_pkg::CSD_BUS_ACK
                                 : csd_pkg::CSD_BUS_IDLE;
      csd_pkg::CSD_BUS_ACK:
        next_bus_state = csd_pkg::CSD_BUS_IDLE;
      default:
        next_bus_state = csd_pkg::CSD_BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bus_state <= csd_pkg::CSD_BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= (next_bus_state == csd_pkg::CSD_BUS_ACK);
  end

  // step register: the only writable field, too small a value is ignored
  // since the shift needs a distinct mid point in every step
  always_ff @(posedge core_clk)
  begin
    if (rst)
      step_div <= csd_pkg::STEP_RESET;
    else if (bus_state == csd_pkg::CSD_BUS_IDLE && bus_req && wb_we_i &&
             wb_sel_i[0] && wb_adr_i == csd_pkg::REG_STEP &&
             wb_dat_i[7:0] >= 8'(csd_pkg::STEP_MIN))
      step_div <= wb_dat_i[7:0];
  end

  // read mux; unmapped addresses read zero and are still acknowledged
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wb_dat_o <= '0;
    else if (bus_state == csd_pkg::CSD_BUS_IDLE && bus_req)
      case (wb_adr_i)
        csd_pkg::REG_DISPLAY: wb_dat_o <= {16'h0000, scan.lamps};
        csd_pkg::REG_KEYS: wb_dat_o <= {22'h000000, pup, drive,
                                        2'b00, key_q};
        csd_pkg::REG_COUNT: wb_dat_o <= {24'h000000, count};
        csd_pkg::REG_STEP: wb_dat_o <= {24'h000000, step_div};
        default: wb_dat_o <= '0;
      endcase
  end

  // check helper: the buffer has no reset, so its bits are known only
  // after a first full scan; the shift check waits for that
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fill_cnt <= '0;
    else if (scan.shift_pulse && fill_cnt != 5'(csd_pkg::DISP_W))
      fill_cnt <= fill_cnt + 5'h01;
  end

  // check helper: shifts seen since the last wrap of the scan counter
  always_ff @(posedge core_clk)
  begin
    if (rst || (step_tick && count == csd_pkg::CNT_MAX))
      sweep_shifts <= '0;
    else if (scan.shift_pulse && sweep_shifts != 5'h1f)
      sweep_shifts <= sweep_shifts + 5'h01;
  end

  // a power-up gap or a new step length restarts a step and may fetch
  // one state twice, so only a sweep without either is counted
  always_ff @(posedge core_clk)
  begin
    if (rst || !pup || (bus_req && wb_we_i && wb_adr_i == csd_pkg::REG_STEP))
      sweep_clean <= 1'b0;
    else if (step_tick && count == csd_pkg::CNT_MAX)
      sweep_clean <= 1'b1;
  end

  property p_wrap;
    @(posedge core_clk) disable iff (rst)
    step_tick && count == csd_pkg::CNT_MAX |=> count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("scan counter did not wrap to zero");

  property p_step_only;
    @(posedge core_clk) disable iff (rst)
    !step_tick |=> $stable(count);
  endproperty
  a_step_only: assert property (p_step_only)
    else $error("scan counter moved without a step");

  property p_no_shift_hold;
    @(posedge core_clk) disable iff (rst)
    count[7:4] != 4'h0 && !scan.shift_pulse ##1 !scan.shift_pulse
      |=> $stable(scan.lamps);
  endproperty
  a_no_shift_hold: assert property (p_no_shift_hold)
    else $error("display changed during hold");

  property p_shift_data;
    @(posedge core_clk) disable iff (rst)
    scan.shift_pulse && fill_cnt == 5'(csd_pkg::DISP_W) |=>
      scan.lamps == {$past(scan.lamps[14:0]), $past(scan.serial_bit)};
  endproperty
  a_shift_data: assert property (p_shift_data)
    else $error("display buffer did not shift in serial bit");

  property p_select;
    @(posedge core_clk) disable iff (rst)
    ##1 scan_select == ~$past(count[3:0]);
  endproperty
  a_select: assert property (p_select)
    else $error("scan select is not the inverted count");

  property p_pulse_in_scan;
    @(posedge core_clk) disable iff (rst)
    scan.shift_pulse |-> $past(count[7:4]) == 4'h0;
  endproperty
  a_pulse_in_scan: assert property (p_pulse_in_scan)
    else $error("shift outside the scan states");

  property p_drive;
    @(posedge core_clk) disable iff (rst)
    ##1 drive == $past(pup && panel_lock);
  endproperty
  a_drive: assert property (p_drive)
    else $error("key drive does not match power-up and lockout");

  property p_pup_low;
    @(posedge core_clk) disable iff (rst)
    !power_good_n |=> !pup ##1 !pup;
  endproperty
  a_pup_low: assert property (p_pup_low)
    else $error("power-up rose before the hold period");

  property p_ack;
    @(posedge core_clk) disable iff (rst)
    bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("wishbone ack not a single cycle pulse");

  property p_sweep;
    @(posedge core_clk) disable iff (rst)
    step_tick && count == csd_pkg::CNT_MAX && sweep_clean |->
      sweep_shifts == 5'(csd_pkg::DISP_W);
  endproperty
  a_sweep: assert property (p_sweep)
    else $error("scan sweep did not fetch sixteen bits");

  c_scan: cover property (@(posedge core_clk) disable iff (rst)
    scan.shift_pulse && count == 8'h0f);
  c_wrap: cover property (@(posedge core_clk) disable iff (rst)
    step_tick && count == csd_pkg::CNT_MAX);
  c_lock: cover property (@(posedge core_clk) disable iff (rst)
    drive && key_active[csd_pkg::KEY_STOP]);
  c_bus: cover property (@(posedge core_clk) disable iff (rst)
    wb_ack_o && wb_we_i);
  c_sweep: cover property (@(posedge core_clk) disable iff (rst)
    step_tick && count == csd_pkg::CNT_MAX && sweep_clean);
endmodule : csd_console

// ### design/csd_display_buf.sv
/*
  sixteen-bit display buffer built of four-bit shift sections.
  assumes shift_pulse and serial_bit come from flops on core_clk.
*/
`timescale 1ns/100ps
module csd_display_buf #(
  parameter int unsigned SECTIONS = 4
) (
  input wire logic core_clk,
  csd_scan_if.buffer scan
);
  initial
  begin
    if (SECTIONS * csd_pkg::SECT_W != csd_pkg::DISP_W)
      $error("csd_display_buf: sections must fill the display");
  end

  logic [csd_pkg::SECT_W-1:0] sect [SECTIONS];
  logic [SECTIONS:0] chain;

  // serial input enters section 0, so the first bit lands in bit 15
  assign chain[0] = scan.serial_bit;

  genvar g;
  generate
    for (g = 0; g < SECTIONS; g++)
    begin : g_sect
      // no reset: contents change only by shifting
      always_ff @(posedge core_clk)
      begin
        if (scan.shift_pulse) // hold when low
          sect[g] <= {sect[g][csd_pkg::SECT_W-2:0], chain[g]};
      end
      assign chain[g+1] = sect[g][csd_pkg::SECT_W-1]; // last feeds next
      assign scan.lamps[g*csd_pkg::SECT_W +: csd_pkg::SECT_W] = sect[g];
    end
  endgenerate
endmodule : csd_display_buf

// ### design/csd_key_latch.sv
/*
  set/reset bounce latches for the console keys.
  assumes key_active is synchronous, 1 while a key is in its active
  position (stop position for the stop/run toggle).
*/
`timescale 1ns/100ps
module csd_key_latch #(
  parameter int unsigned NKEYS = csd_pkg::NKEYS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NKEYS-1:0] key_active,
  input wire logic drive,
  output logic [NKEYS-1:0] latched_n
);
  initial
  begin
    if (NKEYS <= csd_pkg::KEY_STOP)
      $error("csd_key_latch: stop key index out of range");
  end

  genvar k;
  generate
    for (k = 0; k < NKEYS; k++)
    begin : g_key
      logic set_n;
      logic clr_n;
      // rest terminal carries drive to set, active terminal to reset
      always_comb
      begin
        set_n = key_active[k] ? 1'b1 : drive;
        clr_n = key_active[k] ? drive : 1'b1;
        if (k == csd_pkg::KEY_STOP)
          set_n = set_n & ~drive; // inverted drive forces set
      end
      // registered latch: a high drive blocks both terminals, except the forced set of the stop key
      always_ff @(posedge core_clk)
      begin
        if (rst)
          latched_n[k] <= 1'b1;
        else if (!set_n)
          latched_n[k] <= 1'b1;
        else if (!clr_n)
          latched_n[k] <= 1'b0; // asserted low
      end
    end
  endgenerate

  property p_lock_hold;
    @(posedge core_clk) disable iff (rst)
    drive |=> $stable(latched_n[NKEYS-1:1]);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("momentary latch changed under lockout");

  property p_stop_forced;
    @(posedge core_clk) disable iff (rst)
    drive |=> latched_n[csd_pkg::KEY_STOP];
  endproperty
  a_stop_forced: assert property (p_stop_forced)
    else $error("stop latch not forced clear under lockout");

  property p_follow_pos;
    @(posedge core_clk) disable iff (rst)
    !drive |=> latched_n == ~$past(key_active);
  endproperty
  a_follow_pos: assert property (p_follow_pos)
    else $error("latch does not follow key position");
endmodule : csd_key_latch

// ### design/csd_pkg.sv
/*
  constants shared by the console scan/display and key block.
  assumes one 25 MHz core clock and a classic wishbone register port.
*/
package csd_pkg;
  // core clock and console step timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STEP_TIME_NS = 1000;
  localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_MIN = 2;
  // power-up hold after restoration
  localparam int unsigned PUP_HOLD_MS = 70;
  localparam int unsigned PUP_HOLD_CYCLES =
    PUP_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  // scan counter layout
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned DISP_W = 16;
  localparam int unsigned SECT_W = 4;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // key indices
  localparam int unsigned NKEYS = 6;
  localparam int unsigned KEY_STOP = 0;
  localparam int unsigned KEY_SET_ADDR = 1;
  localparam int unsigned KEY_INSPECT = 2;
  localparam int unsigned KEY_RESUME = 3;
  localparam int unsigned KEY_STORE = 4;
  localparam int unsigned KEY_START = 5;
  // register byte offsets
  localparam logic [7:0] REG_DISPLAY = 8'h00;
  localparam logic [7:0] REG_KEYS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_STEP = 8'h0c;
  localparam logic [7:0] STEP_RESET = 8'h19;
  // keys register field positions
  localparam int unsigned KEYS_DRIVE_BIT = 8;
  localparam int unsigned KEYS_PUP_BIT = 9;
  // bus slave states
  typedef enum logic [1:0] {
    CSD_BUS_IDLE = 2'b01,
    CSD_BUS_ACK = 2'b10
  } csd_bus_e;
endpackage : csd_pkg

// ### design/csd_scan_if.sv
/*
  scan path between the console sequencer and the display buffer.
  assumes all signals are driven from flops of the core clock domain.
*/
`timescale 1ns/100ps
interface csd_scan_if;
  logic shift_pulse;
  logic serial_bit;
  logic [15:0] lamps;
  modport ctrl (
    output shift_pulse,
    output serial_bit,
    input lamps
  );
  modport buffer (
    input shift_pulse,
    input serial_bit,
    output lamps
  );
endinterface : csd_scan_if

// ### verification/csd_proc_model.sv
/*
  behavioural model of the processor data leg and power-up level.
  assumes the bench asks for a new word only while no scan must see it.
*/
`timescale 1ns/100ps
module csd_proc_model (
  input wire logic core_clk,
  input wire logic load,
  input wire logic [15:0] word,
  input wire logic power_on,
  output logic [15:0] data_leg,
  output logic power_good_n
);
  // the leg only moves on request, so one sweep sees one settled word
  always_ff @(posedge core_clk)
  begin
    if (load)
      data_leg <= word;
  end
  // power level follows the supply; high means power is good
  always_ff @(posedge core_clk)
  begin
    power_good_n <= power_on;
  end
endmodule : csd_proc_model

// ### verification/tb_csd_console.sv
/*
  self-checking bench for the console scan/display and key block.
  assumes a short power-up hold parameter and a 25 MHz core clock.
*/
`timescale 1ns/100ps
module tb_csd_console;
  localparam int unsigned PUP = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic load = 1'b0;
  logic [15:0] word = 16'h0000;
  logic power_on = 1'b1;
  logic panel_lock = 1'b0;
  logic [5:0] key_active = 6'h00;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [15:0] data_leg;
  logic power_good_n;
  logic [3:0] scan_select;
  logic [15:0] lamps;
  logic [5:0] keys_n;
  logic stop_n;
  logic set_adr_n;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] rd;
  logic [31:0] c0;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'hc86f;

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  csd_proc_model u_csd_proc_model (.core_clk(core_clk), .load(load),
    .word(word), .power_on(power_on), .data_leg(data_leg),
    .power_good_n(power_good_n));

  csd_console #(.PUP_HOLD(PUP)) u_csd_console (.core_clk(core_clk),
    .rst(rst), .data_leg(data_leg), .power_good_n(power_good_n),
    .panel_lock(panel_lock), .key_active(key_active),
    .scan_select(scan_select), .lamps(lamps), .keys_latched_n(keys_n),
    .stop_request_latched_n(stop_n), .set_address_latched_n(set_adr_n),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  task give_verdict;
  begin
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
  begin
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  end
  endtask : chk

  // one classic cycle; the request is held until ack is sampled
  task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
  begin
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 40)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  endtask : wb_xfer

  task cyc(input int n);
  begin
    repeat (n) @(posedge core_clk);
  end
  endtask : cyc

  // resting keys read high, active keys low
  function automatic logic [5:0] exp_keys(input logic [5:0] act);
    return ~act;
  endfunction : exp_keys

  task keys_chk(input logic [5:0] exp);
  begin
    chk({26'h0, keys_n}, {26'h0, exp}, "keys");
    chk({31'h0, stop_n}, {31'h0, exp[0]}, "stop");
    chk({31'h0, set_adr_n}, {31'h0, exp[1]}, "set addr");
  end
  endtask : keys_chk

  // poll the count until the sweep is well inside the hold span
  task wait_hold;
    int n;
  begin
    n = 0;
    do
    begin
      wb_xfer(1'b0, csd_pkg::REG_COUNT, 32'h0, c0);
      n++;
    end while ((c0 < 32 || c0 > 200) && n < 2000);
    if (n >= 2000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  endtask : wait_hold

  initial
  begin
    load <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    load <= 1'b0;
    wb_xfer(1'b0, csd_pkg::REG_STEP, 32'h0, rd);
    chk(rd, 32'h19, "step reset");
    wb_xfer(1'b1, csd_pkg::REG_STEP, 32'h4, rd);
    wb_xfer(1'b1, csd_pkg::REG_STEP, 32'h1, rd);
    wb_xfer(1'b0, csd_pkg::REG_STEP, 32'h0, rd);
    chk(rd, 32'h4, "step refuse");
    wb_xfer(1'b1, 8'h10, 32'hffff, rd);
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    // corner words first, then random ones
    for (int i = 0; i < 5; i++)
    begin
      word <= (i == 0) ? 16'h8001 : (i == 1) ? 16'h0000 : 16'($random(seed));
      load <= 1'b1;
      cyc(1);
      load <= 1'b0;
      cyc(2100);
      wait_hold();
      chk({16'h0, lamps}, {16'h0, word}, "lamps");
      cyc(40);
      chk({16'h0, lamps}, {16'h0, word}, "hold");
      wb_xfer(1'b0, csd_pkg::REG_DISPLAY, 32'h0, rd);
      chk(rd, {16'h0, word}, "display reg");
    end
    // every key, store included, reads low while active and high at rest
    for (int i = 0; i < 8; i++)
    begin
      key_active <= 6'($random(seed));
      cyc(3);
      keys_chk(exp_keys(key_active));
    end
    key_active <= 6'h00;
    cyc(3);
    panel_lock <= 1'b1;
    cyc(3);
    key_active <= 6'h3f;
    cyc(3);
    keys_chk(6'h3f);
    wb_xfer(1'b0, csd_pkg::REG_KEYS, 32'h0, rd);
    chk(rd, 32'h33f, "keys reg");
    // supply drop under lock with the toggle in stop
    key_active <= 6'h01;
    power_on <= 1'b0;
    // model, power-up, drive and latch each take one edge
    cyc(5);
    keys_chk(6'h3e);
    wb_xfer(1'b0, csd_pkg::REG_KEYS, 32'h0, rd);
    chk(rd, 32'h03e, "keys reg off");
    wb_xfer(1'b0, csd_pkg::REG_COUNT, 32'h0, c0);
    cyc(50);
    wb_xfer(1'b0, csd_pkg::REG_COUNT, 32'h0, rd);
    chk(rd, c0, "frozen count");
    chk({28'h0, scan_select}, {28'h0, ~c0[3:0]}, "select");
    power_on <= 1'b1;
    cyc(PUP + 8);
    keys_chk(6'h3f);
    panel_lock <= 1'b0;
    cyc(3);
    keys_chk(6'h3e);
    // supply drop without lock: keys follow position on return
    power_on <= 1'b0;
    key_active <= 6'($random(seed));
    cyc(4);
    keys_chk(exp_keys(key_active));
    power_on <= 1'b1;
    cyc(PUP + 8);
    key_active <= 6'($random(seed));
    cyc(3);
    keys_chk(exp_keys(key_active));
    give_verdict();
  end
endmodule : tb_csd_console
